// ---- inc/scc_pkg.sv ----
package scc_pkg;

  // --------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------
  localparam logic [15:0] OFS_RATE_PLL_CONFIG = 16'h8085;
  localparam logic [15:0] OFS_LANE_PAIR_EN    = 16'h8086;
  localparam logic [15:0] OFS_PLL_POWER_CTRL  = 16'h8087;
  localparam logic [15:0] OFS_LANE_SYNC_STAT  = 16'h8088;
  localparam logic [15:0] OFS_FAIL_OUT_SEL    = 16'h8089;

  // --------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------
  localparam logic [15:0] RST_RATE_PLL_CONFIG = 16'h0A00;
  localparam logic [15:0] RST_LANE_PAIR_EN    = 16'hFFFF;
  localparam logic [15:0] RST_PLL_POWER_CTRL  = 16'h8000;
  localparam logic [15:0] RST_LANE_SYNC_STAT  = 16'h0000;
  localparam logic [15:0] RST_FAIL_OUT_SEL    = 16'h8000;

  // --------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------
  localparam int POS_JOG_MEANING   = 15;
  localparam int POS_RATE_LSB      = 13;
  localparam int POS_SYMBOL_WIDTH  = 12;
  localparam int POS_PLL_LOW_BW    = 11;
  localparam int POS_MULT_LSB      = 8;
  localparam int POS_TX_EN_LSB     = 8;
  localparam int POS_RX_EN_LSB     = 0;
  localparam int POS_PLL_ENABLE    = 15;
  localparam int POS_FAIL_SELECT   = 15;

  // --------------------------------------------------------------------
  // Encodings
  // --------------------------------------------------------------------
  localparam logic [1:0] RATE_FULL    = 2'h0;
  localparam logic [1:0] RATE_HALF    = 2'h1;
  localparam logic [1:0] RATE_QUARTER = 2'h2;

  localparam logic [2:0] MULT_5X  = 3'h0;
  localparam logic [2:0] MULT_25X = 3'h1;
  localparam logic [2:0] MULT_10X = 3'h2;
  localparam logic [2:0] MULT_15X = 3'h3;
  localparam logic [2:0] MULT_4X  = 3'h4;
  localparam logic [2:0] MULT_20X = 3'h5;
  localparam logic [2:0] MULT_8X  = 3'h6;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wrData;
    logic        wr;
    logic        rd;
  } scc_req_t;

  typedef struct packed {
    logic [1:0] rateShift;
    logic       rateValid;
    logic [4:0] multFactor;
    logic       multValid;
  } scc_decode_t;

  typedef struct packed {
    logic [15:0] rateCfg;
    logic [15:0] laneEn;
    logic        pllEnable;
    logic        failSelect;
    logic [7:0]  jogPrev;
    logic [7:0]  commaAlignEnable;
    logic [7:0]  alignJogPulse;
    logic [7:0]  txPairEnable;
    logic [7:0]  rxPairEnable;
    scc_decode_t decode;
    logic        wordIs8Bit;
    logic        pllLowBandwidth;
    logic        failOut;
    logic [15:0] rdData;
    logic        rdValid;
  } scc_state_t;

endpackage

// ---- rtl/scc_field_decode.sv ----
`timescale 1ns/1ns
`default_nettype none

module scc_field_decode (
  input  wire logic [1:0]          lineRateSelect,
  input  wire logic [2:0]          pllMultiplierCode,
  output scc_pkg::scc_decode_t     decode
);

  always_comb begin
    decode = '0;
    case (lineRateSelect)
      scc_pkg::RATE_FULL: begin
        decode.rateShift = 2'h0;
        decode.rateValid = 1'b1;
      end
      scc_pkg::RATE_HALF: begin
        decode.rateShift = 2'h1;
        decode.rateValid = 1'b1;
      end
      scc_pkg::RATE_QUARTER: begin
        decode.rateShift = 2'h2;
        decode.rateValid = 1'b1;
      end
      default: begin
        decode.rateShift = 2'h0;
        decode.rateValid = 1'b0;
      end
    endcase
    decode.multValid = 1'b1;
    case (pllMultiplierCode)
      scc_pkg::MULT_5X:  decode.multFactor = 5'h05;
      scc_pkg::MULT_25X: decode.multFactor = 5'h19;
      scc_pkg::MULT_10X: decode.multFactor = 5'h0A;
      scc_pkg::MULT_15X: decode.multFactor = 5'h0F;
      scc_pkg::MULT_4X:  decode.multFactor = 5'h04;
      scc_pkg::MULT_20X: decode.multFactor = 5'h14;
      scc_pkg::MULT_8X:  decode.multFactor = 5'h08;
      default: begin
        decode.multFactor = 5'h00;
        decode.multValid  = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

// ---- rtl/scc_side_gate.sv ----
`timescale 1ns/1ns
`default_nettype none

module scc_side_gate #(
  parameter int LANES = 4
) (
  input  wire logic [LANES-1:0] txEnable,
  input  wire logic [LANES-1:0] rxEnable,
  input  wire logic             globalPowerDown,
  input  wire logic             sidePowerDown,
  output logic      [LANES-1:0] txPair,
  output logic      [LANES-1:0] rxPair
);

  logic off;

  assign off    = globalPowerDown | sidePowerDown;
  assign txPair = off ? '0 : txEnable;
  assign rxPair = off ? '0 : rxEnable;

endmodule

`default_nettype wire

// ---- rtl/scc_regs.sv ----
// Notes on behaviour
// - The jog meaning bit makes each comma jog input an alignment enable at 0 and a jog trigger at 1, resetting to enable.
// - The line rate field selects full (00, reset), half (01) or quarter (10) rate; 11 is reserved.
// - The symbol width bit selects 10-bit lanes at 0 (reset) and 8-bit lanes at 1.
// - The PLL bandwidth bit selects high bandwidth when clear and low when set, resetting to low.
// - The multiplier field decodes 5x,25x,10x(reset),15x,4x,20x,8x for codes 0 to 6, with 7 reserved.
// - The upper byte of the lane enable register holds transmit enables for lanes 7..0, reset to one.
// - The lower byte holds receive enables for lanes 7..0, one enabling the pair.
// - Global power-down disables every transmit and receive pair regardless of enables.
// - Side A power-down disables lanes 3..0 and side B power-down lanes 7..4, over the enables.
// - Transmit bits 11:8 and receive bits 3:0 belong to side A, bits 15:12 and 7:4 to side B.
// - Sync status bits 15:8 are unsupported comma indicators and always read zero.
// - Sync status bits 7:0 are unsupported loss-of-link indicators and always read zero.
// - Bit 15 of the fail select register picks the test-fail signal driven to the pins, reset 0x8000.
`timescale 1ns/1ns
`default_nettype none

module scc_regs #(
  parameter int LANES = 8
) (
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  input  wire scc_pkg::scc_req_t    regReq,
  output logic      [15:0]          regRdData,
  output logic                      regRdValid,
  input  wire logic                 globalPowerDown,
  input  wire logic                 sidePowerDownA,
  input  wire logic                 sidePowerDownB,
  input  wire logic [LANES-1:0]     commaJogInputs,
  input  wire logic [1:0]           testFailSignals,
  output logic      [LANES-1:0]     commaAlignEnable,
  output logic      [LANES-1:0]     alignJogPulse,
  output logic      [LANES-1:0]     txPairEnable,
  output logic      [LANES-1:0]     rxPairEnable,
  output scc_pkg::scc_decode_t      rateMultDecode,
  output logic                      wordIs8Bit,
  output logic                      pllLowBandwidth,
  output logic                      pllEnable,
  output logic                      failOut
);

  // --------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------
  if (LANES != 8) begin : gLaneCheck
    $error("scc_regs serves exactly eight lanes");
  end

  localparam int HALF = LANES / 2;

  scc_pkg::scc_state_t s;
  scc_pkg::scc_state_t next_s;

  // --------------------------------------------------------------------
  // Field views
  // --------------------------------------------------------------------
  logic                 jogMeaningSelect;
  logic [1:0]           lineRateSelect;
  logic                 symbolWidthSelect;
  logic                 pllLowBw;
  logic [2:0]           pllMultiplierCode;
  logic [LANES-1:0]     txEnableBits;
  logic [LANES-1:0]     rxEnableBits;
  logic [LANES-1:0]     txGated;
  logic [LANES-1:0]     rxGated;
  scc_pkg::scc_decode_t decodeNow;

  assign jogMeaningSelect  = s.rateCfg[scc_pkg::POS_JOG_MEANING];
  assign lineRateSelect    = s.rateCfg[scc_pkg::POS_RATE_LSB +: 2];
  assign symbolWidthSelect = s.rateCfg[scc_pkg::POS_SYMBOL_WIDTH];
  assign pllLowBw          = s.rateCfg[scc_pkg::POS_PLL_LOW_BW];
  assign pllMultiplierCode = s.rateCfg[scc_pkg::POS_MULT_LSB +: 3];
  assign txEnableBits      = s.laneEn[scc_pkg::POS_TX_EN_LSB +: LANES];
  assign rxEnableBits      = s.laneEn[scc_pkg::POS_RX_EN_LSB +: LANES];

  // --------------------------------------------------------------------
  // Decoders and side gating
  // --------------------------------------------------------------------
  scc_field_decode uDecode (
    .lineRateSelect    (lineRateSelect),
    .pllMultiplierCode (pllMultiplierCode),
    .decode            (decodeNow)
  );

  scc_side_gate #(
    .LANES (HALF)
  ) uSideA (
    .txEnable        (txEnableBits[HALF-1:0]),
    .rxEnable        (rxEnableBits[HALF-1:0]),
    .globalPowerDown (globalPowerDown),
    .sidePowerDown   (sidePowerDownA),
    .txPair          (txGated[HALF-1:0]),
    .rxPair          (rxGated[HALF-1:0])
  );

  scc_side_gate #(
    .LANES (HALF)
  ) uSideB (
    .txEnable        (txEnableBits[LANES-1:HALF]),
    .rxEnable        (rxEnableBits[LANES-1:HALF]),
    .globalPowerDown (globalPowerDown),
    .sidePowerDown   (sidePowerDownB),
    .txPair          (txGated[LANES-1:HALF]),
    .rxPair          (rxGated[LANES-1:HALF])
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    next_s = s;

    // Register writes; reserved codes stored as written
    if (regReq.wr) begin
      case (regReq.addr)
        scc_pkg::OFS_RATE_PLL_CONFIG: next_s.rateCfg = regReq.wrData;
        scc_pkg::OFS_LANE_PAIR_EN:    next_s.laneEn  = regReq.wrData;
        scc_pkg::OFS_PLL_POWER_CTRL: begin
          next_s.pllEnable = regReq.wrData[scc_pkg::POS_PLL_ENABLE];
        end
        scc_pkg::OFS_FAIL_OUT_SEL: begin
          next_s.failSelect = regReq.wrData[scc_pkg::POS_FAIL_SELECT];
        end
        default: begin
        end
      endcase
    end

    // Register reads, one cycle latency; unmapped reads return zero
    next_s.rdValid = regReq.rd;
    next_s.rdData  = '0;
    if (regReq.rd) begin
      case (regReq.addr)
        scc_pkg::OFS_RATE_PLL_CONFIG: next_s.rdData = s.rateCfg;
        scc_pkg::OFS_LANE_PAIR_EN:    next_s.rdData = s.laneEn;
        scc_pkg::OFS_PLL_POWER_CTRL: begin
          next_s.rdData[scc_pkg::POS_PLL_ENABLE] = s.pllEnable;
        end
        scc_pkg::OFS_LANE_SYNC_STAT:  next_s.rdData = scc_pkg::RST_LANE_SYNC_STAT;
        scc_pkg::OFS_FAIL_OUT_SEL: begin
          next_s.rdData[scc_pkg::POS_FAIL_SELECT] = s.failSelect;
        end
        default:                      next_s.rdData = '0;
      endcase
    end

    next_s.jogPrev = commaJogInputs;
    if (jogMeaningSelect) begin
      next_s.commaAlignEnable = '0;
      next_s.alignJogPulse    = commaJogInputs & ~s.jogPrev;
    end else begin
      next_s.commaAlignEnable = commaJogInputs;
      next_s.alignJogPulse    = '0;
    end

    next_s.txPairEnable = txGated;
    next_s.rxPairEnable = rxGated;

    next_s.decode          = decodeNow;
    next_s.wordIs8Bit      = symbolWidthSelect;
    next_s.pllLowBandwidth = pllLowBw;
    next_s.failOut = s.failSelect ? testFailSignals[1] : testFailSignals[0];

    if (!nrst) begin
      next_s                  = '0;
      next_s.rateCfg          = scc_pkg::RST_RATE_PLL_CONFIG;
      next_s.laneEn           = scc_pkg::RST_LANE_PAIR_EN;
      next_s.pllEnable        = scc_pkg::RST_PLL_POWER_CTRL[scc_pkg::POS_PLL_ENABLE];
      next_s.failSelect       = scc_pkg::RST_FAIL_OUT_SEL[scc_pkg::POS_FAIL_SELECT];
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    s <= next_s;
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign regRdData        = s.rdData;
  assign regRdValid       = s.rdValid;
  assign commaAlignEnable = s.commaAlignEnable;
  assign alignJogPulse    = s.alignJogPulse;
  assign txPairEnable     = s.txPairEnable;
  assign rxPairEnable     = s.rxPairEnable;
  assign rateMultDecode   = s.decode;
  assign wordIs8Bit       = s.wordIs8Bit;
  assign pllLowBandwidth  = s.pllLowBandwidth;
  assign pllEnable        = s.pllEnable;
  assign failOut          = s.failOut;

endmodule

`default_nettype wire

// ---- sim/scc_regs_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module scc_regs_sva #(
  parameter int LANES = 8
) (
  input wire logic                 mclk,
  input wire logic                 nrst,
  input wire scc_pkg::scc_req_t    regReq,
  input wire logic [15:0]          regRdData,
  input wire logic                 regRdValid,
  input wire logic                 globalPowerDown,
  input wire logic                 sidePowerDownA,
  input wire logic                 sidePowerDownB,
  input wire logic [LANES-1:0]     commaJogInputs,
  input wire logic [1:0]           testFailSignals,
  input wire logic [LANES-1:0]     commaAlignEnable,
  input wire logic [LANES-1:0]     alignJogPulse,
  input wire logic [LANES-1:0]     txPairEnable,
  input wire logic [LANES-1:0]     rxPairEnable,
  input wire scc_pkg::scc_decode_t rateMultDecode,
  input wire logic                 wordIs8Bit,
  input wire logic                 pllLowBandwidth,
  input wire logic                 pllEnable,
  input wire logic                 failOut
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  logic failSel;

  // Mirror of the stored fail select bit
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      failSel <= scc_pkg::RST_FAIL_OUT_SEL[scc_pkg::POS_FAIL_SELECT];
    end else if (regReq.wr && regReq.addr == scc_pkg::OFS_FAIL_OUT_SEL) begin
      failSel <= regReq.wrData[scc_pkg::POS_FAIL_SELECT];
    end
  end

  a_status_reads_zero: assert property (
    regReq.rd && regReq.addr == 16'h8088 |=> regRdValid && regRdData == 16'h0000)
    else $error("sync status read not zero");
  a_global_pd_off: assert property (
    globalPowerDown |=> txPairEnable == '0 && rxPairEnable == '0)
    else $error("global power-down left a pair on");
  a_side_a_off: assert property (
    sidePowerDownA |=> txPairEnable[3:0] == 4'h0 && rxPairEnable[3:0] == 4'h0)
    else $error("side A power-down left a pair on");
  a_side_b_off: assert property (
    sidePowerDownB |=> txPairEnable[7:4] == 4'h0 && rxPairEnable[7:4] == 4'h0)
    else $error("side B power-down left a pair on");
  a_align_follows_jog: assert property (
    commaAlignEnable != '0 |-> alignJogPulse == '0
      && (commaAlignEnable & ~$past(commaJogInputs)) == '0)
    else $error("align enable without its jog input");
  a_jog_pulse_cause: assert property (
    alignJogPulse != '0 |-> (alignJogPulse & ~$past(commaJogInputs)) == '0)
    else $error("jog pulse without its input");
  a_jog_one_shot: assert property (
    alignJogPulse != '0 |=> (alignJogPulse & $past(alignJogPulse)) == '0)
    else $error("jog pulse longer than one cycle");
  a_rate_reserved: assert property (
    !rateMultDecode.rateValid |-> rateMultDecode.rateShift == 2'd0)
    else $error("reserved rate decoded to a shift");
  a_mult_legal: assert property (
    rateMultDecode.multValid |-> rateMultDecode.multFactor inside {5, 25, 10, 15, 4, 20, 8})
    else $error("multiplier factor outside the table");
  a_fail_mux: assert property (
    $past(nrst) |-> failOut == $past(failSel ? testFailSignals[1] : testFailSignals[0]))
    else $error("fail output not from the selected fail source");
endmodule
`default_nettype wire

// ---- sim/scc_mgmt_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module scc_mgmt_model (
  input  wire logic         mclk,
  input  wire logic         aPrimary,
  input  wire logic [15:0]  regRdData,
  input  wire logic         regRdValid,
  output var scc_pkg::scc_req_t regReq
);
  initial regReq = '0;

  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    @(negedge mclk);
    if (aPrimary && addr == 16'h8086) begin
      data = 16'hFFFF;
    end
    regReq = '{addr: addr, wrData: data, wr: 1'b1, rd: 1'b0};
    @(negedge mclk);
    regReq = '0;
  endtask

  task automatic rd(input logic [15:0] addr, output logic [16:0] got);
    @(negedge mclk);
    regReq = '{addr: addr, wrData: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(negedge mclk);
    got = {regRdValid, regRdData};
    regReq = '0;
  endtask
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin nCompared++; if ((a) !== (e)) begin \
  $display("CHECK FAILED %s exp %h got %h", nm, e, a); errCount++; end end
module tb;
  typedef struct { logic [15:0] a, w, e; } scc_row_t;
  logic        mclk, nrst, globalPowerDown, sidePowerDownA, sidePowerDownB, aPrimary;
  logic [7:0]  commaJogInputs, commaAlignEnable, alignJogPulse, txPairEnable, rxPairEnable;
  logic [1:0]  testFailSignals;
  logic [15:0] regRdData;
  logic [16:0] got;
  logic        regRdValid, wordIs8Bit, pllLowBandwidth, pllEnable, failOut;
  scc_pkg::scc_req_t    regReq;
  scc_pkg::scc_decode_t rateMultDecode;
  int          errCount, nCompared, i, j;
  logic [15:0] rstTab [5] = '{16'h0A00, 16'hFFFF, 16'h8000, 16'h0000, 16'h8000};
  logic [4:0]  multTab [8] = '{5'd5, 5'd25, 5'd10, 5'd15, 5'd4, 5'd20, 5'd8, 5'd0};
  logic [2:0]  pdTab [3] = '{3'b100, 3'b010, 3'b001};
  logic [15:0] pdExp [3] = '{16'h0000, 16'hA0C0, 16'h0503};
  scc_row_t    rows [6] = '{'{16'h8085, 16'hFFFF, 16'hFFFF}, '{16'h8086, 16'hA5C3, 16'hA5C3},
    '{16'h8087, 16'hFFFF, 16'h8000}, '{16'h8089, 16'h7FFF, 16'h0000},
    '{16'h8088, 16'hFFFF, 16'h0000}, '{16'h808A, 16'hFFFF, 16'h0000}};

  scc_regs #(.LANES(8)) u_dut (.mclk, .nrst, .regReq, .regRdData, .regRdValid,
    .globalPowerDown, .sidePowerDownA, .sidePowerDownB, .commaJogInputs, .testFailSignals,
    .commaAlignEnable, .alignJogPulse, .txPairEnable, .rxPairEnable, .rateMultDecode,
    .wordIs8Bit, .pllLowBandwidth, .pllEnable, .failOut);
  scc_mgmt_model u_host (.mclk, .aPrimary, .regRdData, .regRdValid, .regReq);

  task automatic end_sim();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_reset();
    `CHK("decode", {2'd0, 1'b1, 5'd10, 1'b1}, rateMultDecode)
    `CHK("pll bits", 4'b0111, {wordIs8Bit, pllLowBandwidth, pllEnable, failOut})
    `CHK("pairs", 16'hFFFF, {txPairEnable, rxPairEnable})
    for (i = 0; i < 5; i++) begin
      u_host.rd(16'h8085 + 16'(i), got);
      `CHK("reset value", {1'b1, rstTab[i]}, got)
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    repeat (5000) @(posedge mclk);
    errCount++;
    end_sim();
  end

  initial begin
    {nrst, globalPowerDown, sidePowerDownA, sidePowerDownB} = 4'b0000;
    aPrimary = 1'b1;
    commaJogInputs = 8'h00;
    testFailSignals = 2'b10;
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    chk_reset();
    $display("test reset done");
    aPrimary = 1'b0;
    for (i = 0; i < 6; i++) begin
      u_host.wr(rows[i].a, rows[i].w);
      u_host.rd(rows[i].a, got);
      `CHK("readback", {1'b1, rows[i].e}, got)
    end
    $display("test table done");
    `CHK("pairs", 16'hA5C3, {txPairEnable, rxPairEnable})
    `CHK("fail out", 1'b0, failOut)
    testFailSignals = 2'b01;
    @(negedge mclk);
    `CHK("fail out", 1'b1, failOut)
    for (i = 0; i < 3; i++) begin
      {globalPowerDown, sidePowerDownA, sidePowerDownB} = pdTab[i];
      @(negedge mclk);
      `CHK("power-down", pdExp[i], {txPairEnable, rxPairEnable})
    end
    {globalPowerDown, sidePowerDownA, sidePowerDownB} = 3'b000;
    $display("test power-down done");
    for (i = 0; i < 4; i++) begin
      for (j = 0; j < 8; j++) begin
        u_host.wr(16'h8085, {1'b0, i[1:0], 1'b1, 1'b0, j[2:0], 8'h00});
        @(negedge mclk);
        `CHK("decode", {(i == 3) ? 2'd0 : i[1:0], i != 3, multTab[j], j != 7}, rateMultDecode)
        `CHK("width bw", 2'b10, {wordIs8Bit, pllLowBandwidth})
      end
    end
    $display("test decode done");
    commaJogInputs = 8'h5A;
    u_host.wr(16'h8085, 16'h0A00);
    @(negedge mclk);
    `CHK("align enable", 16'h5A00, {commaAlignEnable, alignJogPulse})
    commaJogInputs = 8'h00;
    u_host.wr(16'h8085, 16'h8A00);
    @(negedge mclk);
    commaJogInputs = 8'h81;
    @(negedge mclk);
    `CHK("jog pulse", 16'h0081, {commaAlignEnable, alignJogPulse})
    @(negedge mclk);
    `CHK("jog pulse end", 16'h0000, {commaAlignEnable, alignJogPulse})
    $display("test jog done");
    testFailSignals = 2'b10;
    u_host.wr(16'h8087, 16'h0000);
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    chk_reset();
    $display("test mid-run reset done");
    aPrimary = 1'b1;
    u_host.wr(16'h8086, 16'h0F0F);
    @(negedge mclk);
    `CHK("primary enables", 16'hFFFF, {txPairEnable, rxPairEnable})
    $display("test primary side done");
    end_sim();
  end
endmodule
bind scc_regs scc_regs_sva #(.LANES(LANES)) u_sva (.mclk, .nrst, .regReq, .regRdData,
  .regRdValid, .globalPowerDown, .sidePowerDownA, .sidePowerDownB, .commaJogInputs,
  .testFailSignals, .commaAlignEnable, .alignJogPulse, .txPairEnable, .rxPairEnable,
  .rateMultDecode, .wordIs8Bit, .pllLowBandwidth, .pllEnable, .failOut);
`default_nettype wire
